//--- load_monitor_consts.vh
// Register offsets, field positions, reset values and timing constants
`ifndef LOAD_MONITOR_CONSTS_VH
`define LOAD_MONITOR_CONSTS_VH

// ********************************************************
// Register word offsets
// ********************************************************
`define ADDR_ALARM_VALID 16'h0CE1
`define ADDR_RSVD_A 16'h0CE2
`define ADDR_ALARM_FLAGS 16'h0CE3
`define ADDR_RSVD_B 16'h0CE4
`define ADDR_PHASE_A 16'h0CE5
`define ADDR_PHASE_B 16'h0CE7
`define ADDR_PHASE_C 16'h0CE9
`define ADDR_RUN_TIME 16'h0CEB
`define ADDR_RUN_THRESH 16'h0CED
`define ADDR_SET_STAMP 16'h0CEF

// ********************************************************
// Alarm bitmap fields
// ********************************************************
`define BIT_VOLT_LOSS 0
`define BIT_OVERLOAD_AT_LOSS 1
`define ALARM_SRC_WIDTH 11
`define ALARM_RSVD_ZERO 5'h00

// ********************************************************
// Values and reset contents
// ********************************************************
`define WORD_UNAVAILABLE 16'hFFFF
`define VALID_NO 16'h0000
`define VALID_YES 16'h0001
`define FLOAT_INVALID 32'hFFC00000
`define RUN_TIME_RESET 32'h00000000
`define RUN_TIME_MAX 32'hFFFFFFFF
`define THRESH_RESET 32'h00000000
`define STAMP_RESET 32'h00000000
`define PHASE_WORDS 3'h6

// ********************************************************
// Timing
// ********************************************************
`define CLK_PERIOD_NS 100
`define SECOND_NS 1000000000
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)

`endif

//--- phase_current_store.v
// Small word memory holding the phase currents latched at voltage loss
`timescale 1ns/1ps

module phase_current_store (
  mclk,
  wrEn,
  wrIdx,
  wrData,
  rdIdx,
  rdData
);
  input wire mclk;
  input wire wrEn; // Write strobe
  input wire [2:0] wrIdx; // Word index to write
  input wire [15:0] wrData; // Word to store
  input wire [2:0] rdIdx; // Word index to read
  output reg [15:0] rdData; // Registered read word

  reg [15:0] words [0:7]; // Storage array

  // ********************************************************
  // Write and registered read
  // ********************************************************
  always @(posedge mclk) begin
    if (wrEn) begin
      words[wrIdx] <= wrData;
    end
    rdData <= words[rdIdx];
  end
endmodule // phase_current_store

//--- load_monitor_alarm_registers.v
// Load monitoring alarm and operating time register bank
`timescale 1ns/1ps
`include "load_monitor_consts.vh"

// Functional notes
// - Bit 0 flags voltage phase loss
// - Bit 1 flags overload at voltage loss
// - Run time counts only above power threshold
// - Validity word reads 0/1, unavailable FFFF
// - Bits 2-10 other alarms, 11-15 reserved
// - Latch phase currents as floats at loss
// - Offsets 3298 and 3300 reserved, refused
// - Run time is writable retained 32-bit count
// - Power threshold is writable retained float
// - Stamp last set of run time counter
// - Run time registers only on metering classes
module load_monitor_alarm_registers #(
  parameter HAS_RUN_TIME = 1, // Zero for breaker-auxiliary class
  parameter SECOND_CYCLES = `SECOND_CYCLES // Clocks per second
) (
  mclk,
  reset,
  regAddr,
  regRead,
  regWrite,
  regWdata,
  regRdata_reg,
  regAck_reg,
  regError_reg,
  alarmAvail,
  alarmValid,
  voltageLoss,
  currentOverload,
  alarmOther,
  phaseACurrent,
  phaseBCurrent,
  phaseCCurrent,
  activePower,
  nowStamp
);
  input wire mclk;
  input wire reset;
  input wire [15:0] regAddr; // Register word address
  input wire regRead; // Read request pulse
  input wire regWrite; // Write request pulse
  input wire [15:0] regWdata; // Write word
  output reg [15:0] regRdata_reg; // Read word
  output reg regAck_reg; // Answer pulse
  output reg regError_reg; // Refusal pulse, with answer
  input wire alarmAvail; // Alarm information available
  input wire alarmValid; // Alarm bitmap meaningful
  input wire voltageLoss; // Load phase voltage lost
  input wire currentOverload; // Current overload present
  input wire [8:0] alarmOther; // Alarm sources for bits 2 to 10
  input wire [31:0] phaseACurrent; // Live RMS current, float
  input wire [31:0] phaseBCurrent; // Live RMS current, float
  input wire [31:0] phaseCCurrent; // Live RMS current, float
  input wire [31:0] activePower; // Measured active power, float
  input wire [31:0] nowStamp; // Current date-time word

  // ********************************************************
  // Helper functions
  // ********************************************************
  // True when float a is strictly greater than float b
  function floatAbove;
    input [31:0] a;
    input [31:0] b;
    reg aNan;
    reg bNan;
    begin
      aNan = (a[30:23] == 8'hFF) && (a[22:0] != 23'h000000);
      bNan = (b[30:23] == 8'hFF) && (b[22:0] != 23'h000000);
      if (aNan || bNan) begin
        floatAbove = 1'b0;
      end else if (a[31] != b[31]) begin
        floatAbove = !a[31] && ((a[30:0] | b[30:0]) != 31'h00000000);
      end else if (!a[31]) begin
        floatAbove = a[30:0] > b[30:0];
      end else begin
        floatAbove = a[30:0] < b[30:0];
      end
    end
  endfunction

  // Pick high or low half of a two-word register
  function [15:0] halfWord;
    input [31:0] value;
    input lowHalf;
    begin
      halfWord = lowHalf ? value[15:0] : value[31:16];
    end
  endfunction

  // True when addr is either word of the pair starting at base
  function inPair;
    input [15:0] addr;
    input [15:0] base;
    begin
      inPair = (addr == base) || (addr == base + 16'h0001);
    end
  endfunction

  // ********************************************************
  // State encodings
  // ********************************************************
  localparam [1:0] LATCH_IDLE = 2'h1; // Waiting for voltage loss
  localparam [1:0] LATCH_RUN = 2'h2; // Writing current words

  // ********************************************************
  // Declarations
  // ********************************************************
  reg [15:0] alarmFlags_reg; // Alarm bitmap
  reg voltageLossPrev_reg; // Loss level of last cycle
  reg [1:0] latchState_reg; // Current latch sequencer
  reg [1:0] latchState_next;
  reg [2:0] latchIdx_reg; // Word being stored
  reg [95:0] latchSnap_reg; // Currents caught at the loss edge
  reg currentsValid_reg; // Any loss latched yet
  reg [31:0] runTime_reg; // Operating seconds
  reg [31:0] runThresh_reg; // Active power threshold
  reg [31:0] setStamp_reg; // Time of last counter set
  reg [15:0] writeHold_reg; // High word waiting for its low word
  reg [15:0] readHold_reg; // Low word caught when high is read
  reg [23:0] secCount_reg; // Second divider
  reg secTick_reg; // One pulse per second
  reg reqPend_reg; // Request in answer stage
  reg reqErr_reg; // Request refused
  reg reqMem_reg; // Answer comes from memory
  reg [15:0] reqData_reg; // Non-memory read word
  reg memWr;
  reg [15:0] memWdata;
  wire [15:0] memRdata;
  wire [15:0] wordIdx; // Offset from phase A start
  wire inPhase; // Address in current words
  wire inRun; // Address in run time block
  wire lowHalf; // Address is second word of a pair
  wire mapped; // Address answers at all
  wire writable; // Address accepts writes
  reg [15:0] readWord; // Non-memory read mux

  // ********************************************************
  // Alarm bitmap
  // ********************************************************
  // Bits follow their sources each cycle; bit 1 held from loss edge
  always @(posedge mclk) begin
    if (reset) begin
      alarmFlags_reg <= 16'h0000;
      voltageLossPrev_reg <= 1'b0;
    end else begin
      voltageLossPrev_reg <= voltageLoss;
      alarmFlags_reg[`BIT_VOLT_LOSS] <= voltageLoss;
      if (!voltageLoss) begin
        alarmFlags_reg[`BIT_OVERLOAD_AT_LOSS] <= 1'b0;
      end else if (!voltageLossPrev_reg) begin
        alarmFlags_reg[`BIT_OVERLOAD_AT_LOSS] <= currentOverload;
      end
      alarmFlags_reg[10:2] <= alarmOther;
      alarmFlags_reg[15:11] <= `ALARM_RSVD_ZERO;
    end
  end

  // ********************************************************
  // Current latch sequencer
  // ********************************************************
  // Next state of the sequencer
  always @* begin
    latchState_next = latchState_reg;
    case (latchState_reg)
      LATCH_IDLE: begin
        if (voltageLoss && !voltageLossPrev_reg) begin
          latchState_next = LATCH_RUN;
        end
      end
      LATCH_RUN: begin
        if (latchIdx_reg == `PHASE_WORDS - 3'h1) begin
          latchState_next = LATCH_IDLE;
        end
      end
      default: begin
        latchState_next = LATCH_IDLE;
      end
    endcase
  end

  // Snapshot at the loss edge, then store six words in turn
  always @(posedge mclk) begin
    if (reset) begin
      latchState_reg <= LATCH_IDLE;
      latchIdx_reg <= 3'h0;
      latchSnap_reg <= 96'h0;
      currentsValid_reg <= 1'b0;
    end else begin
      latchState_reg <= latchState_next;
      if (latchState_reg == LATCH_IDLE) begin
        latchIdx_reg <= 3'h0;
        if (latchState_next == LATCH_RUN) begin
          latchSnap_reg <= {phaseACurrent, phaseBCurrent,
                            phaseCCurrent};
        end
      end else begin
        latchIdx_reg <= latchIdx_reg + 3'h1;
        latchSnap_reg <= {latchSnap_reg[79:0], 16'h0000};
        if (latchState_next == LATCH_IDLE) begin
          currentsValid_reg <= 1'b1;
        end
      end
    end
  end

  // Memory write port driven by the sequencer only
  always @* begin
    memWr = (latchState_reg == LATCH_RUN);
    memWdata = latchSnap_reg[95:80];
  end

  phase_current_store currentStore (
    .mclk(mclk),
    .wrEn(memWr),
    .wrIdx(latchIdx_reg),
    .wrData(memWdata),
    .rdIdx(wordIdx[2:0]),
    .rdData(memRdata)
  );

  // ********************************************************
  // Second divider
  // ********************************************************
  // Emits one enable pulse every second
  always @(posedge mclk) begin
    if (reset) begin
      secCount_reg <= 24'h000000;
      secTick_reg <= 1'b0;
    end else if (secCount_reg == SECOND_CYCLES[23:0] - 24'h000001) begin
      secCount_reg <= 24'h000000;
      secTick_reg <= 1'b1;
    end else begin
      secCount_reg <= secCount_reg + 24'h000001;
      secTick_reg <= 1'b0;
    end
  end

  // ********************************************************
  // Address decode
  // ********************************************************
  assign wordIdx = regAddr - `ADDR_PHASE_A;
  assign inPhase = (regAddr >= `ADDR_PHASE_A) &&
                   (regAddr < `ADDR_RUN_TIME);
  assign inRun = (HAS_RUN_TIME != 0) && (regAddr >= `ADDR_RUN_TIME) &&
                 (regAddr <= `ADDR_SET_STAMP + 16'h0001);
  assign lowHalf = !regAddr[0];
  assign mapped = (regAddr == `ADDR_ALARM_VALID) ||
                  (regAddr == `ADDR_ALARM_FLAGS) ||
                  inPhase || inRun;
  assign writable = inRun;

  // Read word for registers outside the memory
  always @* begin
    readWord = 16'h0000;
    if (regAddr == `ADDR_ALARM_VALID) begin
      if (!alarmAvail) begin
        readWord = `WORD_UNAVAILABLE;
      end else begin
        readWord = alarmValid ? `VALID_YES : `VALID_NO;
      end
    end else if (regAddr == `ADDR_ALARM_FLAGS) begin
      readWord = alarmAvail ? alarmFlags_reg : `WORD_UNAVAILABLE;
    end else if (inPhase) begin
      readWord = halfWord(`FLOAT_INVALID, lowHalf);
    end else if (inPair(regAddr, `ADDR_RUN_TIME)) begin
      readWord = lowHalf ? readHold_reg : runTime_reg[31:16];
    end else if (inPair(regAddr, `ADDR_RUN_THRESH)) begin
      readWord = lowHalf ? readHold_reg : runThresh_reg[31:16];
    end else if (inPair(regAddr, `ADDR_SET_STAMP)) begin
      readWord = lowHalf ? readHold_reg : setStamp_reg[31:16];
    end
  end

  // ********************************************************
  // Run time, threshold and stamp registers
  // ********************************************************
  // Pair writes commit on the low word; counting saturates
  always @(posedge mclk) begin
    if (reset) begin
      runTime_reg <= `RUN_TIME_RESET;
      runThresh_reg <= `THRESH_RESET;
      setStamp_reg <= `STAMP_RESET;
      writeHold_reg <= 16'h0000;
      readHold_reg <= 16'h0000;
    end else begin
      if (regRead && inRun && !lowHalf) begin
        // Catch low word so a pair reads consistently
        if (regAddr == `ADDR_RUN_TIME) begin
          readHold_reg <= runTime_reg[15:0];
        end else if (regAddr == `ADDR_RUN_THRESH) begin
          readHold_reg <= runThresh_reg[15:0];
        end else begin
          readHold_reg <= setStamp_reg[15:0];
        end
      end
      if (regWrite && writable && !lowHalf) begin
        writeHold_reg <= regWdata; // High word waits
      end
      if (regWrite && writable && lowHalf &&
          regAddr == `ADDR_RUN_TIME + 16'h0001) begin
        runTime_reg <= {writeHold_reg, regWdata};
        setStamp_reg <= nowStamp;
      end else begin
        if (secTick_reg && (HAS_RUN_TIME != 0) &&
            floatAbove(activePower, runThresh_reg) &&
            runTime_reg != `RUN_TIME_MAX) begin
          runTime_reg <= runTime_reg + 32'h00000001;
        end
        if (regWrite && lowHalf &&
            regAddr == `ADDR_SET_STAMP + 16'h0001 && inRun) begin
          setStamp_reg <= {writeHold_reg, regWdata};
        end
      end
      if (regWrite && inRun && lowHalf &&
          regAddr == `ADDR_RUN_THRESH + 16'h0001) begin
        runThresh_reg <= {writeHold_reg, regWdata};
      end
    end
  end

  // ********************************************************
  // Request pipeline and answer
  // ********************************************************
  // Stage one decodes; stage two answers two cycles after request
  always @(posedge mclk) begin
    if (reset) begin
      reqPend_reg <= 1'b0;
      reqErr_reg <= 1'b0;
      reqMem_reg <= 1'b0;
      reqData_reg <= 16'h0000;
      regRdata_reg <= 16'h0000;
      regAck_reg <= 1'b0;
      regError_reg <= 1'b0;
    end else begin
      reqPend_reg <= regRead || regWrite;
      reqErr_reg <= !mapped || (regWrite && !writable);
      reqMem_reg <= regRead && inPhase && currentsValid_reg;
      reqData_reg <= regRead ? readWord : 16'h0000;
      regAck_reg <= reqPend_reg;
      regError_reg <= reqPend_reg && reqErr_reg;
      if (reqPend_reg && !reqErr_reg) begin
        regRdata_reg <= reqMem_reg ? memRdata : reqData_reg;
      end else begin
        regRdata_reg <= 16'h0000;
      end
    end
  end
endmodule // load_monitor_alarm_registers

//--- modbus_client_model.sv
// Supervision client model issuing register requests to the bank
`timescale 1ns/1ps

module modbus_client_model (
  input wire logic mclk,
  output logic [15:0] regAddr,
  output logic regRead,
  output logic regWrite,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata_reg,
  input wire logic regAck_reg,
  input wire logic regError_reg
);
  int idleGap = 0; // Idle cycles before each request, slow client

  // ********************************************************
  // Request driver
  // ********************************************************
  // Bus quiet from time zero
  initial begin
    regAddr = 16'h0000;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWdata = 16'h0000;
  end

  // One word transfer: pulse request, then wait for the answer
  task automatic xfer(input logic isWr, input logic [15:0] addr,
    input logic [15:0] wd, output logic [15:0] rd, output logic e);
    rd = 16'hXXXX;
    e = 1'bX;
    repeat (idleGap) @(posedge mclk);
    @(posedge mclk);
    regAddr <= addr;
    regRead <= !isWr;
    regWrite <= isWr;
    regWdata <= wd;
    @(posedge mclk);
    regRead <= 1'b0;
    regWrite <= 1'b0;
    regAddr <= ~addr; // Released lines show no stale value
    regWdata <= ~wd;
    for (int n = 0; n < 6; n++) begin
      @(posedge mclk);
      if (regAck_reg === 1'b1) begin
        rd = regRdata_reg;
        e = regError_reg;
        break;
      end
    end
  endtask

  // Pair write, high word first, low word commits
  task automatic wr32(input logic [15:0] addr, input logic [31:0] v,
    output logic e);
    logic [15:0] q;
    logic e1;
    xfer(1'b1, addr, v[31:16], q, e1);
    xfer(1'b1, addr + 16'h0001, v[15:0], q, e);
    e = e | e1;
  endtask

  // Pair read, high word first
  task automatic rd32(input logic [15:0] addr, output logic [31:0] v,
    output logic e);
    logic e1;
    xfer(1'b0, addr, 16'h0000, v[31:16], e1);
    xfer(1'b0, addr + 16'h0001, 16'h0000, v[15:0], e);
    e = e | e1;
  endtask
endmodule // modbus_client_model

//--- load_monitor_alarm_monitor.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ps

module load_monitor_alarm_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [15:0] regRdata_reg,
  input wire logic regAck_reg,
  input wire logic regError_reg,
  input wire logic alarmAvail,
  input wire logic alarmValid,
  input wire logic voltageLoss,
  input wire logic [8:0] alarmOther
);
  // ********************************************************
  // Answer timing and read contents
  // ********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_ack_latency: assert property ((regRead || regWrite) |->
    ##2 regAck_reg)
    else $error("request not answered two cycles later");
  a_ack_cause: assert property (regAck_reg |->
    $past(regRead || regWrite, 2))
    else $error("answer without a request");
  a_err_ack: assert property (regError_reg |-> regAck_reg)
    else $error("refusal without answer");
  a_quiet_data: assert property (!regAck_reg |->
    regRdata_reg == 16'h0000)
    else $error("read word not zero outside answer");
  a_rsvd_refused: assert property ((regRead || regWrite) &&
    (regAddr == 16'h0CE2 || regAddr == 16'h0CE4) |->
    ##2 (regError_reg && regRdata_reg == 16'h0000))
    else $error("reserved word not refused");
  a_ro_write: assert property (regWrite && regAddr < 16'h0CEB |->
    ##2 regError_reg)
    else $error("write to read-only word accepted");
  a_unavail_word: assert property ((regRead && !alarmAvail &&
    (regAddr == 16'h0CE1 || regAddr == 16'h0CE3)) ##1 !alarmAvail |->
    ##1 regRdata_reg == 16'hFFFF)
    else $error("unavailable word not FFFF");
  a_valid_word: assert property ((regRead && regAddr == 16'h0CE1 &&
    alarmAvail) ##1 (alarmAvail && $stable(alarmValid)) |->
    ##1 regRdata_reg == {15'h0000, $past(alarmValid)})
    else $error("validity word wrong");
  a_flag_bits: assert property (($stable(voltageLoss) &&
    $stable(alarmOther)) ##1 (regRead && regAddr == 16'h0CE3 && alarmAvail
    && $stable(voltageLoss) && $stable(alarmOther)) ##1 (alarmAvail &&
    $stable(voltageLoss) && $stable(alarmOther)) |-> ##1
    (regRdata_reg[0] == $past(voltageLoss) && regRdata_reg[15:11] == 5'h00
    && regRdata_reg[10:2] == $past(alarmOther)
    && (!regRdata_reg[1] || $past(voltageLoss))))
    else $error("alarm bitmap differs from sources");
endmodule // load_monitor_alarm_monitor

bind load_monitor_alarm_registers load_monitor_alarm_monitor mon (
  .mclk(mclk), .reset(reset), .regAddr(regAddr), .regRead(regRead),
  .regWrite(regWrite), .regRdata_reg(regRdata_reg),
  .regAck_reg(regAck_reg), .regError_reg(regError_reg),
  .alarmAvail(alarmAvail), .alarmValid(alarmValid),
  .voltageLoss(voltageLoss), .alarmOther(alarmOther));

//--- load_monitor_alarm_registers_tb.sv
// Self-checking bench for the load monitor register bank
`timescale 1ns/1ps
`include "load_monitor_consts.vh"

module load_monitor_alarm_registers_tb;
  localparam int SEC = 20; // Shortened seconds tick
  logic mclk, reset, alarmAvail, alarmValid, voltageLoss, currentOverload;
  logic regRead, regWrite, regAck_reg, regError_reg, err;
  logic [15:0] regAddr, regWdata, regRdata_reg, word, ef;
  logic [15:0] auxRdata; // Read word of the breaker-auxiliary twin
  logic auxAck, auxErr; // Answer and refusal of the twin
  logic [8:0] alarmOther;
  logic [31:0] phaseACurrent, phaseBCurrent, phaseCCurrent, activePower;
  logic [31:0] nowStamp, lfsr, got;
  logic [31:0] lat [3]; // Currents expected to be latched
  int err_count = 0;
  int cmp_count = 0;

  load_monitor_alarm_registers #(.HAS_RUN_TIME(1), .SECOND_CYCLES(SEC)) uut (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata_reg(regRdata_reg),
    .regAck_reg(regAck_reg), .regError_reg(regError_reg),
    .alarmAvail(alarmAvail), .alarmValid(alarmValid),
    .voltageLoss(voltageLoss), .currentOverload(currentOverload),
    .alarmOther(alarmOther), .phaseACurrent(phaseACurrent),
    .phaseBCurrent(phaseBCurrent), .phaseCCurrent(phaseCCurrent),
    .activePower(activePower), .nowStamp(nowStamp));
  // Breaker-auxiliary class twin on the same bus, no run time block
  load_monitor_alarm_registers #(.HAS_RUN_TIME(0), .SECOND_CYCLES(SEC))
    uutAux (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata_reg(auxRdata),
    .regAck_reg(auxAck), .regError_reg(auxErr),
    .alarmAvail(alarmAvail), .alarmValid(alarmValid),
    .voltageLoss(voltageLoss), .currentOverload(currentOverload),
    .alarmOther(alarmOther), .phaseACurrent(phaseACurrent),
    .phaseBCurrent(phaseBCurrent), .phaseCCurrent(phaseCCurrent),
    .activePower(activePower), .nowStamp(nowStamp));
  modbus_client_model client (
    .mclk(mclk), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata_reg(regRdata_reg),
    .regAck_reg(regAck_reg), .regError_reg(regError_reg));

  // ********************************************************
  // Clock, helpers and verdict
  // ********************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Pseudo-random step
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected bitmap: overload only counts while loss holds
  function automatic logic [15:0] expFlags(input logic loss, input logic ovl,
    input logic [8:0] other);
    return {5'h00, other, loss & ovl, loss};
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic expect16(input logic [15:0] a, input logic [15:0] e,
    input logic eErr);
    client.xfer(1'b0, a, 16'h0000, word, err);
    check({16'h0000, word}, {16'h0000, e});
    check(32'(err), 32'(eErr));
  endtask

  task automatic expect32(input logic [15:0] a, input logic [31:0] e);
    client.rd32(a, got, err);
    check(got, e);
    check(32'(err), 32'h00000000);
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung bus
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    reset = 1'b1;
    {alarmAvail, alarmValid, voltageLoss, currentOverload} = 4'h0;
    alarmOther = 9'h000;
    {phaseACurrent, phaseBCurrent, phaseCCurrent} = 96'h0;
    {activePower, nowStamp} = 64'h0;
    lfsr = 32'h00015F82;
    lat = '{default: `FLOAT_INVALID};
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    // Reset contents and refusals
    for (int i = 0; i < 3; i++) begin
      expect32(`ADDR_RUN_TIME + 16'(2 * i), 32'h00000000);
    end
    expect16(`ADDR_RSVD_A, 16'h0000, 1'b1);
    expect16(`ADDR_RSVD_B, 16'h0000, 1'b1);
    expect16(16'h0000, 16'h0000, 1'b1);
    client.xfer(1'b0, `ADDR_RUN_TIME, 16'h0000, word, err);
    check(32'({auxAck, auxErr, auxRdata}), 32'h00030000);
    client.xfer(1'b1, `ADDR_ALARM_FLAGS, 16'hFFFF, word, err);
    check(32'(err), 32'h00000001);
    client.xfer(1'b1, `ADDR_PHASE_A, 16'hFFFF, word, err);
    check(32'(err), 32'h00000001);
    // Validity word: unavailable, invalid, valid
    expect16(`ADDR_ALARM_VALID, `WORD_UNAVAILABLE, 1'b0);
    check(32'({auxAck, auxErr, auxRdata}), 32'h0002FFFF);
    expect16(`ADDR_ALARM_FLAGS, `WORD_UNAVAILABLE, 1'b0);
    alarmAvail <= 1'b1;
    expect16(`ADDR_ALARM_VALID, `VALID_NO, 1'b0);
    alarmValid <= 1'b1;
    expect16(`ADDR_ALARM_VALID, `VALID_YES, 1'b0);
    // Random alarms, loss toggling, latch held against live changes
    for (int k = 0; k < 8; k++) begin
      lfsr = nextRand(lfsr);
      @(posedge mclk);
      phaseACurrent <= lfsr;
      phaseBCurrent <= ~lfsr;
      phaseCCurrent <= lfsr ^ 32'h5A5A5A5A;
      {alarmOther, currentOverload} <= lfsr[9:0];
      repeat (2) @(posedge mclk);
      voltageLoss <= k[0];
      if (k[0]) begin
        lat = '{lfsr, ~lfsr, lfsr ^ 32'h5A5A5A5A};
      end
      repeat (10) @(posedge mclk);
      currentOverload <= ~lfsr[0];
      phaseACurrent <= 32'h00000000;
      repeat (3) @(posedge mclk);
      ef = expFlags(k[0], lfsr[0], lfsr[9:1]);
      expect16(`ADDR_ALARM_FLAGS, ef, 1'b0);
      for (int p = 0; p < 3; p++) begin
        expect32(`ADDR_PHASE_A + 16'(2 * p), lat[p]);
      end
    end
    // Run time: idle below threshold, counting above it
    client.wr32(`ADDR_RUN_THRESH, 32'h42C80000, err);
    check(32'(err), 32'h00000000);
    activePower <= 32'h3F800000;
    repeat (5 * SEC) @(posedge mclk);
    expect32(`ADDR_RUN_TIME, 32'h00000000);
    expect32(`ADDR_RUN_THRESH, 32'h42C80000);
    activePower <= 32'h43480000;
    repeat (5 * SEC) @(posedge mclk);
    client.rd32(`ADDR_RUN_TIME, got, err);
    check(32'(got >= 32'h4 && got <= 32'h6), 32'h00000001);
    // Slow client: set counter near top, stamp, saturation
    client.idleGap = 3;
    nowStamp <= lfsr;
    client.wr32(`ADDR_RUN_TIME, 32'hFFFFFFFE, err);
    check(32'(err), 32'h00000000);
    expect32(`ADDR_SET_STAMP, lfsr);
    repeat (3 * SEC) @(posedge mclk);
    expect32(`ADDR_RUN_TIME, `RUN_TIME_MAX);
    report_and_stop();
  end
endmodule // load_monitor_alarm_registers_tb
